/* rtl/ocd_top.sv */
// oscillator output, vco divider and analog delay configuration
// assumes a serial-port loader on core_clk presents whole words with wr_en
//
// Behaviour
// - delay is 500 ps plus code times 25, codes above 23 clamped to 23
// - delay only where selected, else powered down
// - delay codes in bits 9:5 and 15:11
// - second output amplitude 700/1200/1600/2000 mVpp
// - first output format decode, four classes
// - first output needs enable and a format other than 0 and 15
// - bit 23 enables second output
// - path bits select bypass or divided input
// - bit 19 powers down input buffer
// - output divider: 0 is 8, 1-2 are 2
// - divide by one only through bypass
// - bit 12 picks vco or vco divider
// - bit 11 powers the feedback mux
// - vco divider: 0 is 8, 1-2 are 2
// - unselected or external vco counts ratio one
// - distribution mode bypasses the loops
// - qualified sync uses feedback mux output
`timescale 1ns/1ps
module ocd_top (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  input  wire logic [3:0]  rd_addr,
  output logic [31:0]      rd_data,
  input  wire logic [4:0]  device_mode,
  input  wire logic        ext_vco,
  input  wire logic        qualified_sync,
  output logic [5:0]       group_delay_on,
  output logic [11:0]      output_delay_apply,
  output logic [65:0]      group_delay_ps,
  output logic             first_osc_on,
  output ocd_pkg::ocd_fmt_t first_osc_class,
  output logic [1:0]       first_osc_level,
  output logic             second_osc_on,
  output logic [10:0]      second_osc_mvpp,
  output logic             first_osc_divided,
  output logic             second_osc_divided,
  output logic             first_loop_fb_divided,
  output logic             osc_in_buffer_on,
  output logic [3:0]       osc_div_ratio,
  output logic [3:0]       vco_divider_ratio_ratio,
  output logic             dist_from_vco_divider_ratio,
  output logic             feedback_mux_on,
  output logic             sync_from_fb_mux,
  output logic             loops_bypassed
);
  logic [31:0] cfg_q [3];
  logic [31:0] cfg_d [3];
  logic [31:0] osc_q;
  logic [31:0] osc_d;

  function automatic logic [3:0] div_ratio(input logic [2:0] code);
    // code 0 means 8, codes 1 and 2 both mean 2
    case (code)
      3'h0:    div_ratio = 4'h8;
      3'h1:    div_ratio = 4'h2;
      default: div_ratio = {1'b0, code};
    endcase
  endfunction

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      cfg_d[i] = cfg_q[i];
    end
    osc_d = osc_q;
    if (wr_en)
    begin
      case (wr_addr)
        ocd_pkg::OFS_CFG_A:   cfg_d[0] = wr_data;
        ocd_pkg::OFS_CFG_B:   cfg_d[1] = wr_data;
        ocd_pkg::OFS_CFG_C:   cfg_d[2] = wr_data;
        ocd_pkg::OFS_OSC_CTL: osc_d = wr_data;
        default:              osc_d = osc_q;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 3; i++)
      begin
        cfg_q[i] <= ocd_pkg::RST_WORD;
      end
      osc_q <= ocd_pkg::RST_WORD;
    end
    else
    begin
      cfg_q <= cfg_d;
      osc_q <= osc_d;
    end
  end

  always_comb
  begin
    case (rd_addr)
      ocd_pkg::OFS_CFG_A:   rd_data = cfg_q[0];
      ocd_pkg::OFS_CFG_B:   rd_data = cfg_q[1];
      ocd_pkg::OFS_CFG_C:   rd_data = cfg_q[2];
      ocd_pkg::OFS_OSC_CTL: rd_data = osc_q;
      default:              rd_data = 32'h0000_0000;
    endcase
  end

  // two groups per word, lower group first
  for (genvar g = 0; g < 6; g++)
  begin : g_grp
    localparam int unsigned LSB = (g % 2 == 0) ? ocd_pkg::ADLY_LO_LSB
                                               : ocd_pkg::ADLY_HI_LSB;
    ocd_delay_group u_grp (
      .delay_code (cfg_q[g/2][LSB +: ocd_pkg::ADLY_W]),
      .sel_lo     (cfg_q[g/2][ocd_pkg::SEL_LO_BIT]),
      .sel_hi     (cfg_q[g/2][ocd_pkg::SEL_HI_BIT]),
      .block_on   (group_delay_on[g]),
      .apply_lo   (output_delay_apply[2*g]),
      .apply_hi   (output_delay_apply[2*g+1]),
      .delay_ps   (group_delay_ps[11*g +: 11])
    );
  end

  logic [3:0] fmt;
  logic       dist_mode;
  always_comb
  begin
    fmt = osc_q[ocd_pkg::FMT_LSB +: 4];
    dist_mode = (device_mode == ocd_pkg::MODE_DIST);
    first_osc_level = 2'b00;
    if (fmt == ocd_pkg::FMT_LVDS)
      first_osc_class = ocd_pkg::OCD_FMT_LVDS;
    else if (fmt >= ocd_pkg::FMT_PECL_LO && fmt <= ocd_pkg::FMT_PECL_HI)
    begin
      first_osc_class = ocd_pkg::OCD_FMT_LVPECL;
      first_osc_level = 2'(fmt - ocd_pkg::FMT_PECL_LO);
    end
    else if (fmt > ocd_pkg::FMT_PECL_HI && fmt <= ocd_pkg::FMT_CMOS_HI)
      first_osc_class = ocd_pkg::OCD_FMT_LVCMOS;
    else
      first_osc_class = ocd_pkg::OCD_FMT_OFF;
    first_osc_on = osc_q[ocd_pkg::EN1_BIT]
                   && first_osc_class != ocd_pkg::OCD_FMT_OFF;
    second_osc_on = osc_q[ocd_pkg::EN2_BIT];
    case (osc_q[ocd_pkg::AMP_LSB +: 2])
      2'h0:    second_osc_mvpp = ocd_pkg::AMP_700;
      2'h1:    second_osc_mvpp = ocd_pkg::AMP_1200;
      2'h2:    second_osc_mvpp = ocd_pkg::AMP_1600;
      default: second_osc_mvpp = ocd_pkg::AMP_2000;
    endcase
    // ratio one exists only as the bypass path
    first_osc_divided = osc_q[ocd_pkg::MUX1_BIT];
    second_osc_divided = osc_q[ocd_pkg::MUX2_BIT];
    // host must fold this ratio into the loop divide value
    first_loop_fb_divided = first_osc_divided;
    osc_in_buffer_on = !osc_q[ocd_pkg::PDIN_BIT];
    osc_div_ratio = div_ratio(osc_q[ocd_pkg::ODIV_LSB +: 3]);
    // external vco or direct path counts as ratio one
    dist_from_vco_divider_ratio = osc_q[ocd_pkg::VMUX_BIT] && !ext_vco;
    vco_divider_ratio_ratio = dist_from_vco_divider_ratio
                    ? div_ratio(osc_q[ocd_pkg::VDIV_LSB +: 3])
                    : 4'h1;
    feedback_mux_on = osc_q[ocd_pkg::FBEN_BIT];
    sync_from_fb_mux = qualified_sync && feedback_mux_on;
    loops_bypassed = dist_mode;
  end

  a_osc_enable: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    first_osc_on == (osc_q[ocd_pkg::EN1_BIT] && fmt != 4'h0 && fmt != 4'hf))
    else $error("first output power wrong");
  a_fmt_off: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    fmt == 4'h0 |-> first_osc_class == ocd_pkg::OCD_FMT_OFF && !first_osc_on)
    else $error("powerdown format not off");
  a_fmt_lvds: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    fmt == ocd_pkg::FMT_LVDS |-> first_osc_class == ocd_pkg::OCD_FMT_LVDS)
    else $error("lvds format wrong");
  a_pecl_top: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    fmt == ocd_pkg::FMT_PECL_HI |-> first_osc_class == ocd_pkg::OCD_FMT_LVPECL
    && first_osc_level == 2'h3)
    else $error("top pecl level wrong");
  a_fmt_cmos: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    fmt > ocd_pkg::FMT_PECL_HI && fmt <= ocd_pkg::FMT_CMOS_HI
    |-> first_osc_class == ocd_pkg::OCD_FMT_LVCMOS)
    else $error("cmos format wrong");

  a_amp_max: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    osc_q[ocd_pkg::AMP_LSB +: 2] == 2'h3
    |-> second_osc_mvpp == ocd_pkg::AMP_2000)
    else $error("amplitude wrong");
  a_amp_min: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    osc_q[ocd_pkg::AMP_LSB +: 2] == 2'h0
    |-> second_osc_mvpp == ocd_pkg::AMP_700)
    else $error("lowest amplitude wrong");
  a_second_en: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    second_osc_on == osc_q[ocd_pkg::EN2_BIT])
    else $error("second output enable wrong");
  a_first_path: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    first_osc_divided == osc_q[ocd_pkg::MUX1_BIT])
    else $error("first output path wrong");
  a_second_path: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    second_osc_divided == osc_q[ocd_pkg::MUX2_BIT])
    else $error("second output path wrong");
  a_fb_folded: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    first_loop_fb_divided == osc_q[ocd_pkg::MUX1_BIT])
    else $error("loop feedback flag wrong");

  a_buf_pd: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    $rose(osc_q[ocd_pkg::PDIN_BIT]) |-> !osc_in_buffer_on)
    else $error("input buffer not down");
  a_buf_normal: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !osc_q[ocd_pkg::PDIN_BIT] |-> osc_in_buffer_on)
    else $error("input buffer not up");
  a_div_eight: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    osc_q[ocd_pkg::ODIV_LSB +: 3] == 3'h0 |-> osc_div_ratio == 4'h8)
    else $error("divider code zero not eight");
  a_div_two: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    osc_q[ocd_pkg::ODIV_LSB +: 3] inside {3'h1, 3'h2}
    |-> osc_div_ratio == 4'h2)
    else $error("divider codes one and two not two");
  a_div_never_one: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    osc_div_ratio != 4'h1)
    else $error("divider field gave ratio one");

  a_vco_source: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    osc_q[ocd_pkg::VMUX_BIT] && !ext_vco |-> dist_from_vco_divider_ratio)
    else $error("vco divider path not taken");
  a_fb_mux_pwr: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    feedback_mux_on == osc_q[ocd_pkg::FBEN_BIT])
    else $error("feedback mux power wrong");
  a_vco_code: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    dist_from_vco_divider_ratio && osc_q[ocd_pkg::VDIV_LSB +: 3] == 3'h0
    |-> vco_divider_ratio_ratio == 4'h8)
    else $error("vco divider code zero not eight");
  a_vco_ratio: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !osc_q[ocd_pkg::VMUX_BIT] |-> vco_divider_ratio_ratio == 4'h1)
    else $error("direct vco ratio not one");
  a_vco_ext: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    ext_vco |-> vco_divider_ratio_ratio == 4'h1 && !dist_from_vco_divider_ratio)
    else $error("external vco ratio not one");
  a_dist_bypass: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    loops_bypassed == (device_mode == ocd_pkg::MODE_DIST))
    else $error("distribution bypass wrong");
  a_qual_sync: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    qualified_sync && feedback_mux_on |-> sync_from_fb_mux)
    else $error("qualified sync not routed");

  a_write_lands: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    wr_en && wr_addr == ocd_pkg::OFS_OSC_CTL |=> osc_q == $past(wr_data))
    else $error("control word not latched");
  a_cfg_lands: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    wr_en && wr_addr == ocd_pkg::OFS_CFG_C |=> cfg_q[2] == $past(wr_data))
    else $error("configuration word not latched");
  a_delay_off: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !cfg_q[0][ocd_pkg::SEL_LO_BIT] && !cfg_q[0][ocd_pkg::SEL_HI_BIT]
    |-> !group_delay_on[0] && group_delay_ps[10:0] == 11'h000)
    else $error("unused delay block on");
  a_delay_apply: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    output_delay_apply[9:8] ==
    {cfg_q[2][ocd_pkg::SEL_HI_BIT], cfg_q[2][ocd_pkg::SEL_LO_BIT]})
    else $error("delay applied to wrong output");
  a_delay_val: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    cfg_q[2][ocd_pkg::SEL_HI_BIT]
    && cfg_q[2][ocd_pkg::ADLY_LO_LSB +: 5] == 5'h03
    |-> group_delay_ps[54:44] == 11'h23f)
    else $error("delay step wrong");
  a_delay_clamp: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    cfg_q[1][ocd_pkg::SEL_LO_BIT]
    && cfg_q[1][ocd_pkg::ADLY_HI_LSB +: 5] > ocd_pkg::ADLY_MAX
    |-> group_delay_ps[43:33] == 11'h433)
    else $error("delay clamp wrong");
endmodule

/* include/ocd_pkg.sv */
// constants for the oscillator output and vco divider configuration block
// assumes registers arrive as whole 32-bit words with a 4-bit address
package ocd_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_CFG_A = 4'h6;
  localparam logic [3:0] OFS_CFG_B = 4'h7;
  localparam logic [3:0] OFS_CFG_C = 4'h8;
  localparam logic [3:0] OFS_OSC_CTL = 4'ha;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // delay code fields in each output configuration word
  localparam int unsigned ADLY_LO_LSB = 5;
  localparam int unsigned ADLY_HI_LSB = 11;
  localparam int unsigned ADLY_W = 5;
  localparam int unsigned SEL_LO_BIT = 28;
  localparam int unsigned SEL_HI_BIT = 29;
  localparam logic [4:0] ADLY_MAX = 5'h17;
  localparam logic [9:0] ADLY_FIXED_PS = 10'h1f4;
  localparam logic [9:0] ADLY_STEP_PS = 10'h019;
  // oscillator control word fields
  localparam int unsigned AMP_LSB = 30;
  localparam int unsigned FMT_LSB = 24;
  localparam int unsigned EN2_BIT = 23;
  localparam int unsigned EN1_BIT = 22;
  localparam int unsigned MUX2_BIT = 21;
  localparam int unsigned MUX1_BIT = 20;
  localparam int unsigned PDIN_BIT = 19;
  localparam int unsigned ODIV_LSB = 16;
  localparam int unsigned VMUX_BIT = 12;
  localparam int unsigned FBEN_BIT = 11;
  localparam int unsigned VDIV_LSB = 8;
  localparam logic [10:0] AMP_700 = 11'h2bc;
  localparam logic [10:0] AMP_1200 = 11'h4b0;
  localparam logic [10:0] AMP_1600 = 11'h640;
  localparam logic [10:0] AMP_2000 = 11'h7d0;
  localparam logic [4:0] MODE_DIST = 5'h10;
  typedef enum logic [1:0] {
    OCD_FMT_OFF    = 2'b00,
    OCD_FMT_LVDS   = 2'b01,
    OCD_FMT_LVPECL = 2'b10,
    OCD_FMT_LVCMOS = 2'b11
  } ocd_fmt_t;
  localparam logic [3:0] FMT_LVDS = 4'h1;
  localparam logic [3:0] FMT_PECL_LO = 4'h2;
  localparam logic [3:0] FMT_PECL_HI = 4'h5;
  localparam logic [3:0] FMT_CMOS_HI = 4'he;
endpackage

/* rtl/ocd_delay_group.sv */
// one clock group analog delay decode
// assumes code and selects are registered configuration fields
`timescale 1ns/1ps
module ocd_delay_group (
  input  wire logic [4:0] delay_code,
  input  wire logic       sel_lo,
  input  wire logic       sel_hi,
  output logic            block_on,
  output logic            apply_lo,
  output logic            apply_hi,
  output logic [10:0]     delay_ps
);
  logic [4:0] code_c;
  always_comb
  begin
    // codes above the table clamp to the largest step
    code_c = (delay_code > ocd_pkg::ADLY_MAX) ? ocd_pkg::ADLY_MAX : delay_code;
    block_on = sel_lo | sel_hi;
    apply_lo = sel_lo;
    apply_hi = sel_hi;
    // 11 bits: the top code reaches 1075 ps, past a 10-bit range
    delay_ps = block_on ? 11'(11'(ocd_pkg::ADLY_FIXED_PS)
               + 11'(code_c * ocd_pkg::ADLY_STEP_PS)) : 11'h000;
  end
endmodule

/* dv/ocd_host.sv */
// host model: writes whole configuration words on core_clk
// assumes the bench calls put_word only after reset release
`timescale 1ns/1ps
module ocd_host (
  input  wire logic        core_clk,
  output logic             wr_en,
  output logic [3:0]       wr_addr,
  output logic [31:0]      wr_data
);
  initial
  begin
    wr_en = 1'b0;
    wr_addr = 4'h0;
    wr_data = 32'h0000_0000;
  end
  // one word per strobe, then the data lines turn over so no stale copy
  task automatic put_word(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(posedge core_clk);
    #1;
    wr_en = 1'b0;
    wr_data = ~d;
  endtask
endmodule

/* dv/osc_output_and_vco_divider_config_bench.sv */
// bench for ocd_top: host model writes words, bench checks decoded levels
// assumes outputs settle within 1 ns of the write edge
`timescale 1ns/1ps
module osc_output_and_vco_divider_config_bench;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        wr_en;
  logic [3:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  rd_addr = 4'h0;
  logic [31:0] rd_data;
  logic [4:0]  device_mode = 5'h00;
  logic        ext_vco = 1'b0;
  logic        qsync = 1'b0;
  logic [5:0]  g_on;
  logic [11:0] apply;
  logic [65:0] g_ps;
  logic        o1_on, o2_on, o1_div, o2_div, fb_div, in_on, vsel, fbm, sfb, byp;
  ocd_pkg::ocd_fmt_t o1_cls;
  logic [1:0]  o1_lvl;
  logic [10:0] o2_mv;
  logic [3:0]  odiv, vdiv;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #50 core_clk = ~core_clk;
  ocd_host i_ocd_host (.core_clk(core_clk), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data));
  ocd_top i_ocd_top (.core_clk(core_clk), .arst_n(arst_n), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
    .rd_data(rd_data), .device_mode(device_mode), .ext_vco(ext_vco),
    .qualified_sync(qsync), .group_delay_on(g_on),
    .output_delay_apply(apply), .group_delay_ps(g_ps),
    .first_osc_on(o1_on), .first_osc_class(o1_cls),
    .first_osc_level(o1_lvl), .second_osc_on(o2_on),
    .second_osc_mvpp(o2_mv), .first_osc_divided(o1_div),
    .second_osc_divided(o2_div), .first_loop_fb_divided(fb_div),
    .osc_in_buffer_on(in_on), .osc_div_ratio(odiv), .vco_divider_ratio_ratio(vdiv),
    .dist_from_vco_divider_ratio(vsel), .feedback_mux_on(fbm),
    .sync_from_fb_mux(sfb), .loops_bypassed(byp));
  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [3:0] ratio(input logic [2:0] c);
    return (c == 3'h0) ? 4'h8 : ((c < 3'h3) ? 4'h2 : {1'b0, c});
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_ocd_host.put_word(a, d);
  endtask
  task automatic t_reset;
    chk("in_on", in_on, 1);
    chk("odiv", odiv, 8);
    chk("o1_on", o1_on, 0);
    chk("o2_on", o2_on, 0);
    rd_addr = ocd_pkg::OFS_CFG_A;
    #1;
    chk("rd_a", rd_data, 0);
  endtask
  // codes 0 and 31 probe the fixed offset and the clamp together
  task automatic t_delay;
    wr(ocd_pkg::OFS_CFG_B, 32'h3000_f800);
    rd_addr = ocd_pkg::OFS_CFG_B;
    #1;
    chk("rd_b", rd_data, 32'h3000_f800);
    chk("g_on", g_on, 6'h0c);
    chk("apply", apply, 12'h0f0);
    chk("ps_lo", g_ps[32:22], 500);
    chk("ps_hi", g_ps[43:33], 1075);
    wr(ocd_pkg::OFS_CFG_B, 32'h0000_0ae0);
    chk("g_off", g_on, 0);
    chk("ps_off", g_ps[43:22], 0);
    // upper select alone on the last word
    wr(ocd_pkg::OFS_CFG_C, 32'h2000_0060);
    rd_addr = ocd_pkg::OFS_CFG_C;
    #1;
    chk("rd_c", rd_data, 32'h2000_0060);
    chk("g_on_c", g_on, 6'h30);
    chk("apply_c", apply, 12'ha00);
    chk("ps_c_lo", g_ps[54:44], 575);
    chk("ps_c_hi", g_ps[65:55], 500);
  endtask
  task automatic t_div;
    logic [10:0] mv [4];
    mv = '{11'h2bc, 11'h4b0, 11'h640, 11'h7d0};
    for (int i = 0; i < 8; i++)
    begin
      wr(ocd_pkg::OFS_OSC_CTL, (i << 30) | (i << 16) | (i << 8) | 32'h1000);
      chk("odiv", odiv, ratio(i));
      chk("vdiv", vdiv, ratio(i));
      chk("mvpp", o2_mv, mv[i % 4]);
    end
    ext_vco = 1'b1;
    @(posedge core_clk);
    #1;
    chk("vdiv_ext", vdiv, 1);
    chk("vsel_ext", vsel, 0);
    ext_vco = 1'b0;
    wr(ocd_pkg::OFS_OSC_CTL, 32'h0000_0500);
    chk("vdiv_dir", vdiv, 1);
    chk("vsel", vsel, 0);
  endtask
  // distribution mode lets the host power the input buffer down
  task automatic t_fmt;
    logic [1:0] c;
    device_mode = ocd_pkg::MODE_DIST;
    for (int f = 0; f < 16; f++)
    begin
      wr(ocd_pkg::OFS_OSC_CTL, (f << 24) | 32'h0058_0800);
      c = (f == 0 || f == 15) ? 0 : (f == 1) ? 1 : (f < 6) ? 2 : 3;
      chk("o1_on", o1_on, c != 0);
      chk("o1_cls", o1_cls, c);
      if (c == 2)
        chk("o1_lvl", o1_lvl, f - 2);
      chk("o1_div", o1_div, 1);
      chk("fb_div", fb_div, 1);
      chk("o2_div", o2_div, 0);
      chk("in_on", in_on, 0);
      chk("fbm", fbm, 1);
      chk("byp", byp, 1);
    end
    // qualification only while the feedback mux is powered
    qsync = 1'b1;
    @(posedge core_clk);
    #1;
    chk("sfb", sfb, 1);
    qsync = 1'b0;
    // leave distribution mode only once the input buffer is back up
    wr(ocd_pkg::OFS_OSC_CTL, 32'h00a1_0000);
    device_mode = 5'h00;
    rd_addr = ocd_pkg::OFS_OSC_CTL;
    #1;
    chk("sfb0", sfb, 0);
    chk("rd_osc", rd_data, 32'h00a1_0000);
    chk("o1_en0", o1_on, 0);
    chk("o2_on", o2_on, 1);
    chk("o2_div", o2_div, 1);
    chk("byp0", byp, 0);
    wr(4'h9, 32'hffff_ffff);
    rd_addr = 4'h9;
    #1;
    chk("rd_unmapped", rd_data, 0);
    chk("o2_keep", o2_on, 1);
  endtask
  task automatic test_done;
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      test_done();
    end
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_delay();
    t_div();
    t_fmt();
    test_done();
  end
endmodule
